// ---- bench/aaes_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
// Bus timing and register behaviour seen at the top ports
module aaes_sva #(
	parameter logic [15:0] MAX_EVT_ONE = 16'h00ff,
	parameter logic [15:0] MAX_EVT_TWO = 16'h00ff
) (
	input wire logic        MCLK, RESET_N, CYC_I, STB_I, WE_I, ACK_O,
	input wire logic [11:0] ADR_I,
	input wire logic [3:0]  SEL_I,
	input wire logic [31:0] DAT_I, DAT_O,
	input wire logic [2:0]  COUNTER_ENABLE,
	input wire logic [15:0] EVENT_NUMBER_ONE, EVENT_NUMBER_TWO, EVENT_NUMBER_THREE
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RESET_N);
	sequence s_take; CYC_I && STB_I && !ACK_O; endsequence
	sequence s_rd; ACK_O && !WE_I; endsequence
	property p_ack; s_take |=> ACK_O ##1 !ACK_O; endproperty
	property p_cause; $rose(ACK_O) |-> $past(CYC_I && STB_I); endproperty
	property p_hi; s_rd |-> DAT_O[31:16] == 16'h0000; endproperty
	property p_rd; s_rd and ADR_I == 12'h0484 |-> DAT_O[15:0] == EVENT_NUMBER_ONE; endproperty
	property p_unm; s_rd and ADR_I == 12'h0500 |-> DAT_O == 32'h0000_0000; endproperty
	property p_wr; ACK_O && WE_I && ADR_I == 12'h0484 && SEL_I[1:0] == 2'b11
		&& DAT_I[15:0] <= MAX_EVT_ONE && !$past(COUNTER_ENABLE[0])
		|-> EVENT_NUMBER_ONE == DAT_I[15:0]; endproperty
	property p_chg; $changed(EVENT_NUMBER_ONE) |-> ACK_O && WE_I && !$past(COUNTER_ENABLE[0]);
	endproperty
	property p_max; EVENT_NUMBER_TWO <= MAX_EVT_TWO; endproperty
	// Reset must clear state even though the other checks are off meanwhile
	property p_rst; disable iff (1'b0) !RESET_N |=> !ACK_O && EVENT_NUMBER_ONE == 16'h0000;
	endproperty
	a_ack: assert property (p_ack) else $error("ack late or not a pulse");
	a_cause: assert property (p_cause) else $error("ack with no request");
	a_hi: assert property (p_hi) else $error("upper read bits not zero");
	a_rd: assert property (p_rd) else $error("read differs from event out");
	a_unm: assert property (p_unm) else $error("unmapped read not zero");
	a_wr: assert property (p_wr) else $error("write not taken");
	a_chg: assert property (p_chg) else $error("event changed without write");
	a_max: assert property (p_max) else $error("unsupported event held");
	a_rst: assert property (p_rst) else $error("reset value wrong");
endmodule // aaes_sva
bind aaes_top aaes_sva #(.MAX_EVT_ONE(MAX_EVT_ONE), .MAX_EVT_TWO(MAX_EVT_TWO)) u_sva (.*);
`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "aaes_map.vh"
module tb;
	logic        mclk = 0, reset_n = 0, cyc = 0, stb = 0, we = 0, ack;
	logic [11:0] adr = 0;
	logic [31:0] di = 0, dout, v;
	logic [2:0]  en = 0;
	logic [11:0] ofs[3] = '{`AAES_OFS_SEL_ONE, `AAES_OFS_SEL_TWO, `AAES_OFS_SEL_THREE};
	logic [31:0] exp_q[$];
	int          n_errors = 0, compares = 0;
	// 50 MHz clock
	always #10 mclk = ~mclk;
	aaes_top i_dut (.MCLK(mclk), .RESET_N(reset_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
		.ADR_I(adr), .SEL_I(4'hf), .DAT_I(di), .DAT_O(dout), .ACK_O(ack),
		.COUNTER_ENABLE(en), .EVENT_NUMBER_ONE(), .EVENT_NUMBER_TWO(),
		.EVENT_NUMBER_THREE());
	task automatic final_report;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		compares++;
		if (seen !== want) begin
			n_errors++;
			$display("mismatch at %0t: got %h want %h", $time, seen, want);
		end
	endtask
	// One classic cycle; a read queues d as its expected data
	task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		i = 0;
		if (!w) exp_q.push_back(d);
		{cyc, stb, we, adr, di} <= {2'b11, w, a, d};
		do @(posedge mclk); while (ack !== 1'b1 && ++i < 20);
		{cyc, stb} <= 2'b00;
		@(posedge mclk);
		if (i == 20) begin
			n_errors++;
			final_report();
		end
	endtask
	// Read data is sampled at the ack edge, before the slave moves on
	always @(posedge mclk) if (ack === 1'b1 && we === 1'b0) chk(dout, exp_q.pop_front());
	initial begin
		v = $urandom(32'h0000_c835);
		repeat (12) @(posedge mclk);
		reset_n <= 1;
		@(posedge mclk);
		for (int k = 0; k < 3; k++) wb(0, ofs[k], 0);
		$display("reset values done");
		for (int k = 0; k < 3; k++) begin
			v = $urandom & 32'hffff_00ff;
			wb(1, ofs[k], v);
			wb(0, ofs[k], v & 32'h0000_00ff);
		end
		$display("write and read back done");
		// Refused writes must keep the old value
		wb(1, ofs[2], 32'h0000_0100);
		wb(0, ofs[2], v & 32'h0000_00ff);
		en <= 3'b100;
		wb(1, ofs[2], 32'h0000_0001);
		wb(0, ofs[2], v & 32'h0000_00ff);
		wb(0, `AAES_OFS_STATUS, 32'h0000_000c);
		wb(0, 12'h0500, 0);
		$display("refusals done");
		final_report();
	end
endmodule // tb
`default_nettype wire

// ---- pkg/aaes_map.vh ----
`ifndef AAES_MAP_VH
`define AAES_MAP_VH
// Register byte offsets
`define AAES_OFS_SEL_ONE     12'h0484
`define AAES_OFS_SEL_TWO     12'h0488
`define AAES_OFS_SEL_THREE   12'h048C
// Offset of the status register: counter enables and last write refused
`define AAES_OFS_STATUS      12'h0490
// Field layout
`define AAES_EVT_MSB         15
`define AAES_EVT_LSB         0
`define AAES_EVT_W           16
`define AAES_RES_MSB         24
`define AAES_RES_LSB         16
// Reset values
`define AAES_RES_RESET       9'h000
`define AAES_EVT_RESET       16'h0000
// Number of selection registers
`define AAES_NUM_SEL         3
`endif

// ---- rtl/aaes_sel_store.v ----
`timescale 1ns/1ps
`default_nettype none
`include "aaes_map.vh"

// Storage for the three event numbers; read data leaves a register
module aaes_sel_store (
	input  wire                         clk,
	input  wire                         reset_n,
	input  wire                         wr_en,
	input  wire [1:0]                   wr_idx,
	input  wire [`AAES_EVT_W-1:0]       wr_data,
	input  wire [1:0]                   rd_idx,
	output reg  [`AAES_EVT_W-1:0]       rd_data,
	output wire [3*`AAES_EVT_W-1:0]     all_data
);
	reg [`AAES_EVT_W-1:0] mem [0:`AAES_NUM_SEL-1];
	genvar g;

	// Each word is a plain register so all three can steer counters at once
	generate
		for (g = 0; g < `AAES_NUM_SEL; g = g + 1) begin : g_word
			always @(posedge clk) begin
				if (!reset_n)
					mem[g] <= `AAES_EVT_RESET;
				else if (wr_en && wr_idx == g)
					mem[g] <= wr_data;
			end
			assign all_data[g*`AAES_EVT_W +: `AAES_EVT_W] = mem[g];
		end
	endgenerate

	// Registered read port
	always @(posedge clk) begin
		if (!reset_n)
			rd_data <= `AAES_EVT_RESET;
		else if (rd_idx < 2'd3)
			rd_data <= mem[rd_idx];
		else
			rd_data <= `AAES_EVT_RESET;
	end
endmodule // aaes_sel_store
`default_nettype wire

// ---- rtl/aaes_top.v ----
`timescale 1ns/1ps
`default_nettype none
`include "aaes_map.vh"

// Functional notes
// RULE_01: Three selection registers at 0x484, 0x488, 0x48C for auxiliary counters one to three.
// RULE_02: Each register is 32 bits and always present, no build option removes it.
// RULE_03: Bits 15:0 hold the event number the matching counter counts; hard-wired counters here read the stored value, not their wired event.
// RULE_04: Reset per field; bits 24:16 reset to zero.
// RULE_05: Supported event numbers are fixed per counter by the implementer.
// RULE_06: Unsupported write may count anything; readback may be any value.
// RULE_07: A hard-wired counter makes the event field read-only.
// RULE_08: Software must not write a selection while its counter is enabled.
// RULE_09: Bits 31:16 read zero and writes to them are ignored.
module aaes_top #(
	parameter [2:0]  FIXED_MASK  = 3'b000,        // Counters with hard-wired event
	parameter [47:0] FIXED_EVT   = 48'h0000_0000_0000,
	parameter [15:0] MAX_EVT_ONE = 16'h00FF,      // Highest supported event number
	parameter [15:0] MAX_EVT_TWO = 16'h00FF,
	parameter [15:0] MAX_EVT_THR = 16'h00FF
) (
	input  wire        MCLK,
	input  wire        RESET_N,
	input  wire        CYC_I,
	input  wire        STB_I,
	input  wire        WE_I,
	input  wire [11:0] ADR_I,
	input  wire [3:0]  SEL_I,
	input  wire [31:0] DAT_I,
	output reg  [31:0] DAT_O,
	output reg         ACK_O,
	input  wire [2:0]  COUNTER_ENABLE,
	output wire [15:0] EVENT_NUMBER_ONE,
	output wire [15:0] EVENT_NUMBER_TWO,
	output wire [15:0] EVENT_NUMBER_THREE
);
	wire [47:0] max_evt = {MAX_EVT_THR, MAX_EVT_TWO, MAX_EVT_ONE};

	// Map a byte address to a selection index; 3 means none
	function [1:0] sel_index;
		input [11:0] adr;
		begin
			case (adr)
				`AAES_OFS_SEL_ONE:   sel_index = 2'd0; // [RULE_01]
				`AAES_OFS_SEL_TWO:   sel_index = 2'd1; // [RULE_01]
				`AAES_OFS_SEL_THREE: sel_index = 2'd2; // [RULE_01]
				default:             sel_index = 2'd3;
			endcase
		end
	endfunction

	wire        req      = CYC_I && STB_I && !ACK_O;
	wire [1:0]  idx      = sel_index(ADR_I);
	wire        is_sel   = (idx != 2'd3);
	wire        is_stat  = (ADR_I == `AAES_OFS_STATUS);
	wire [15:0] stored;
	wire [47:0] all_evt;
	reg         refused;
	reg         rd_sel;   // Read data comes from the store
	reg  [31:0] rd_other;

	// Write lanes: only the two low byte lanes reach the event field
	wire [15:0] wr_merge = {SEL_I[1] ? DAT_I[15:8] : stored_cur[15:8],
		SEL_I[0] ? DAT_I[7:0] : stored_cur[7:0]};
	reg  [15:0] stored_cur;
	always @* begin
		stored_cur = all_evt[15:0];
		if (idx == 2'd1)
			stored_cur = all_evt[31:16];
		else if (idx == 2'd2)
			stored_cur = all_evt[47:32];
	end

	// Writes blocked on hard-wired counters, unsupported numbers or enabled counters
	wire fixed_hit = is_sel && FIXED_MASK[idx];                          // [RULE_07]
	wire over_max  = is_sel && (wr_merge > max_evt[idx*16 +: 16]);       // [RULE_05]
	wire busy_hit  = is_sel && COUNTER_ENABLE[idx];                      // [RULE_08]
	wire wr_ok     = req && WE_I && is_sel && (SEL_I[1:0] != 2'b00)
		&& !fixed_hit && !over_max && !busy_hit;                         // [RULE_06]

	aaes_sel_store u_store (
		.clk      (MCLK),
		.reset_n  (RESET_N),
		.wr_en    (wr_ok),
		.wr_idx   (idx),
		.wr_data  (wr_merge), // [RULE_09]
		.rd_idx   (idx),
		.rd_data  (stored),
		.all_data (all_evt)
	);

	// Outputs to counters: fixed events win over the stored value
	genvar g;
	wire [47:0] eff_evt;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_eff
			assign eff_evt[g*16 +: 16] = FIXED_MASK[g] ? FIXED_EVT[g*16 +: 16]
				: all_evt[g*16 +: 16]; // [RULE_03] [RULE_07]
		end
	endgenerate
	assign EVENT_NUMBER_ONE   = eff_evt[15:0];
	assign EVENT_NUMBER_TWO   = eff_evt[31:16];
	assign EVENT_NUMBER_THREE = eff_evt[47:32];

	// Bus answer: one wait state, ack dropped the cycle after it is given
	always @(posedge MCLK) begin
		if (!RESET_N) begin
			ACK_O    <= 1'b0;
			rd_sel   <= 1'b0;
			rd_other <= 32'h0000_0000;
			refused  <= 1'b0;
		end else begin
			ACK_O <= req;
			if (req) begin
				rd_sel   <= is_sel;
				rd_other <= is_stat ? {28'h000_0000, refused, COUNTER_ENABLE} : 32'h0000_0000;
				if (WE_I && is_sel)
					refused <= !wr_ok;
			end
		end
	end

	// Upper bits read zero; fixed counters read the stored value, not their wired event
	always @* begin
		DAT_O = rd_other;
		if (rd_sel)
			DAT_O = {16'h0000, stored}; // [RULE_04] [RULE_09] [RULE_02]
	end
endmodule // aaes_top
`default_nettype wire
